// *** hdl/pad_decomposer.sv ***
// Primitive assembly: groups vertices of a topology into basic objects
//
// Behaviour
// RULE_01: Source sends triangle/rect counts per limits
// RULE_02: Source sends line/point counts per limits
// RULE_03: Buffer vertices, emit when object complete
// RULE_04: Object carries its vertex count
// RULE_05: Object carries flip-winding flag
// RULE_06: Object carries rear-facing flag
// RULE_07: Flat-shade selector from provoking settings
// RULE_08: Polygon pattern flag, off for plain fans
// RULE_09: Line pattern carry flag per line
// RULE_10: Target slice index forwarded unchanged
// RULE_11: Each point vertex supplies its selectors
// RULE_12: Line list first vertex supplies selectors
// RULE_13: Strip segment leading vertex supplies viewport
// RULE_14: Tri/rect list first vertex supplies selectors
// RULE_15: Tri strip leading vertex supplies viewport
// RULE_16: Fans and polygons use vertex zero
// RULE_17: Point list: one object per vertex
// RULE_18: Rear point lists set rear-facing flag
// RULE_19: Line list pairs, carry flag cleared
// RULE_20: Line strip overlapping pairs in order
// RULE_21: Rear line strips set rear-facing flag
// RULE_22: Carry strips start carried; then always carried
// RULE_23: Triangle list in independent triples
// RULE_24: Stall input under downstream backpressure
// RULE_25: Restart grouping at every new topology
`timescale 1ns/1ns
module pad_decomposer
  import pad_pkg::*;
(
  // Clock and reset
  input  wire logic            clk,
  input  wire logic            srst,
  // Provoking vertex configuration
  input  wire pad_provoke_type provoke_cfg,
  // Vertex stream from clip stage
  input  wire logic            vtx_valid,
  output logic                 vtx_ready,
  input  wire pad_vertex_type  vtx_in,
  // Object stream to object setup
  output logic                 obj_valid,
  input  wire logic            obj_ready,
  output pad_object_type       obj_out,
  // Status
  output logic                 busy
);

  // Everything the assembler remembers between vertices
  typedef struct packed {
    pad_vertex_type   anchor;
    pad_vertex_type   prev;
    logic [1:0]       held;
    logic             odd;
    logic             carry;
    logic             out_valid;
    pad_object_type   out;
  } pad_asm_state_type;

  pad_asm_state_type  st_q;
  pad_asm_state_type  st_d;
  logic               f_valid;
  logic               f_ready;
  pad_vertex_type     f_vtx;

  // RULE_03: vertex buffer
  // RULE_24: fifo ready reaches source
  pad_fifo #(
    .WIDTH (VERTEX_W),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .clk       (clk),
    .srst      (srst),
    .in_valid  (vtx_valid),
    .in_ready  (vtx_ready),
    .in_data   (vtx_in),
    .out_valid (f_valid),
    .out_ready (f_ready),
    .out_data  (f_vtx)
  );

  // RULE_24: consume only when output slot free or taken this cycle
  assign f_ready   = !st_q.out_valid || obj_ready;
  assign obj_valid = st_q.out_valid;
  assign obj_out   = st_q.out;
  assign busy      = f_valid || st_q.out_valid || (st_q.held != 2'h0);

  always_comb begin
    pad_vertex_type v;
    logic [1:0]     held;
    logic           odd;
    logic           carry;
    logic           emit;
    pad_object_type o;

    v     = f_vtx;
    held  = st_q.held;
    odd   = st_q.odd;
    carry = st_q.carry;
    emit  = 1'b0;
    o     = '0;
    st_d  = st_q;

    if (st_q.out_valid && obj_ready) begin
      st_d.out_valid = 1'b0;
    end

    if (f_valid && f_ready) begin
      // RULE_25: topology start clears grouping
      if (v.topo_start) begin
        held  = 2'h0;
        odd   = 1'b0;
        carry = (v.topology_kind == topo_line_strip_carry) ||
                (v.topology_kind == topo_line_strip_carry_rear);
      end
      o.target_slice_index = st_q.anchor.target_slice_sel;
      o.viewport_select    = st_q.anchor.viewport_sel;
      unique case (v.topology_kind)
        topo_point_list, topo_point_list_rear: begin
          // RULE_17: point per vertex, selector zero
          emit                  = 1'b1;
          o.object_kind         = obj_point;
          // RULE_04: point count
          o.object_vertex_count = VCNT_POINT;
          o.vertex0             = v.vertex_data;
          // RULE_11: own selectors
          o.viewport_select     = v.viewport_sel;
          o.target_slice_index  = v.target_slice_sel;
          // RULE_06: rear-facing flag
          // RULE_18: rear points
          o.rear_facing         = (v.topology_kind == topo_point_list_rear);
        end
        topo_line_list, topo_line_strip, topo_line_strip_rear,
        topo_line_strip_carry, topo_line_strip_carry_rear: begin
          o.object_kind           = obj_line;
          o.object_vertex_count   = VCNT_LINE;
          o.vertex0               = st_q.anchor.vertex_data;
          o.vertex1               = v.vertex_data;
          // RULE_07: line provoking setting
          o.flat_shade_vertex_sel = provoke_cfg.line_sel;
          // RULE_21: rear strips
          o.rear_facing           = (v.topology_kind == topo_line_strip_rear) ||
                                    (v.topology_kind == topo_line_strip_carry_rear);
          if (held == 2'h0) begin
            held = 2'h1;
          end else begin
            emit = 1'b1;
            if (v.topology_kind == topo_line_list) begin
              // RULE_19: pairs, carry cleared
              // RULE_12: first of pair supplies selectors
              held                 = 2'h0;
              o.line_pattern_carry = 1'b0;
            end else begin
              // RULE_20: overlapping segments
              // RULE_13: leading vertex supplies viewport
              // RULE_09: carry flag per line
              // RULE_22: carried after each segment
              o.line_pattern_carry = carry;
              carry                = 1'b1;
            end
          end
        end
        topo_tri_list, topo_rect_list: begin
          // RULE_23: independent triples
          // RULE_14: first of three supplies selectors
          o.object_kind           = (v.topology_kind == topo_rect_list) ? obj_rectangle : obj_triangle;
          o.object_vertex_count   = (v.topology_kind == topo_rect_list) ? VCNT_RECT : VCNT_TRI;
          o.vertex0               = st_q.anchor.vertex_data;
          o.vertex1               = st_q.prev.vertex_data;
          o.vertex2               = v.vertex_data;
          o.flat_shade_vertex_sel = (v.topology_kind == topo_rect_list) ? 2'h0 : provoke_cfg.tri_sel;
          // RULE_08: stipple on for triangles and rectangles
          o.polygon_pattern_on    = 1'b1;
          if (held == 2'h2) begin
            emit = 1'b1;
            held = 2'h0;
          end else begin
            held = held + 2'h1;
          end
        end
        topo_tri_strip, topo_tri_strip_rev: begin
          o.object_kind           = obj_triangle;
          o.object_vertex_count   = VCNT_TRI;
          o.vertex0               = st_q.anchor.vertex_data;
          o.vertex1               = st_q.prev.vertex_data;
          o.vertex2               = v.vertex_data;
          o.flat_shade_vertex_sel = provoke_cfg.tri_sel;
          o.polygon_pattern_on    = 1'b1;
          // RULE_05: winding alternates per triangle
          o.flip_winding          = odd ^ (v.topology_kind == topo_tri_strip_rev);
          if (held == 2'h2) begin
            // RULE_15: leading vertex of each triangle
            emit = 1'b1;
            odd  = !odd;
          end else begin
            held = held + 2'h1;
          end
        end
        default: begin
          // Fans, plain fans and polygons share vertex zero
          o.object_kind           = obj_triangle;
          o.object_vertex_count   = VCNT_TRI;
          o.vertex0               = st_q.anchor.vertex_data;
          o.vertex1               = st_q.prev.vertex_data;
          o.vertex2               = v.vertex_data;
          o.flat_shade_vertex_sel = (v.topology_kind == topo_polygon) ? 2'h0 : provoke_cfg.fan_sel;
          // RULE_08: plain fan disables stipple
          o.polygon_pattern_on    = (v.topology_kind != topo_tri_fan_plain);
          if (held == 2'h2) begin
            // RULE_16: vertex zero supplies viewport
            emit = 1'b1;
          end else begin
            held = held + 2'h1;
          end
        end
      endcase

      // Anchor is the leading vertex of the next object
      if (held == 2'h1) begin
        st_d.anchor = v;
      end else if (emit && (v.topology_kind inside {topo_line_strip, topo_line_strip_rear,
                                                    topo_line_strip_carry, topo_line_strip_carry_rear})) begin
        st_d.anchor = v;
      end else if (emit && (v.topology_kind inside {topo_tri_strip, topo_tri_strip_rev})) begin
        st_d.anchor = st_q.prev;
      end
      st_d.prev = v;
      // RULE_25: drop held vertices at topology end
      if (v.topo_end) begin
        held = 2'h0;
      end
      st_d.held  = held;
      st_d.odd   = odd;
      st_d.carry = carry;
      if (emit) begin
        // RULE_10: slice index passed through
        st_d.out       = o;
        st_d.out_valid = 1'b1;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end
endmodule

// *** hdl/pad_pkg.sv ***
// Package of types and constants for the primitive assembly decomposer
package pad_pkg;

  localparam int VTX_DATA_W  = 32;
  localparam int VP_SEL_W    = 4;
  localparam int SLICE_W     = 11;
  localparam int FIFO_DEPTH  = 16;

  typedef enum logic [3:0] {
    topo_point_list,
    topo_point_list_rear,
    topo_line_list,
    topo_line_strip,
    topo_line_strip_rear,
    topo_line_strip_carry,
    topo_line_strip_carry_rear,
    topo_tri_list,
    topo_tri_strip,
    topo_tri_strip_rev,
    topo_tri_fan,
    topo_tri_fan_plain,
    topo_polygon,
    topo_rect_list
  } pad_topology_kind_type;

  typedef enum logic [1:0] {
    obj_point,
    obj_line,
    obj_triangle,
    obj_rectangle
  } pad_object_kind_type;

  localparam logic [1:0] VCNT_POINT = 2'h1;
  localparam logic [1:0] VCNT_LINE  = 2'h2;
  localparam logic [1:0] VCNT_TRI   = 2'h3;
  localparam logic [1:0] VCNT_RECT  = 2'h3;

  // One vertex as delivered by the clip stage
  typedef struct packed {
    pad_topology_kind_type   topology_kind;
    logic                    topo_start;
    logic                    topo_end;
    logic [VTX_DATA_W-1:0]   vertex_data;
    logic [VP_SEL_W-1:0]     viewport_sel;
    logic [SLICE_W-1:0]      target_slice_sel;
  } pad_vertex_type;

  localparam int VERTEX_W = $bits(pad_vertex_type);

  // One basic object handed to object setup
  typedef struct packed {
    pad_object_kind_type     object_kind;
    logic [1:0]              object_vertex_count;
    logic [VTX_DATA_W-1:0]   vertex0;
    logic [VTX_DATA_W-1:0]   vertex1;
    logic [VTX_DATA_W-1:0]   vertex2;
    logic                    flip_winding;
    logic                    rear_facing;
    logic [1:0]              flat_shade_vertex_sel;
    logic                    polygon_pattern_on;
    logic                    line_pattern_carry;
    logic [VP_SEL_W-1:0]     viewport_select;
    logic [SLICE_W-1:0]      target_slice_index;
  } pad_object_type;

  // Programmable provoking vertex settings
  typedef struct packed {
    logic [1:0] line_sel;
    logic [1:0] tri_sel;
    logic [1:0] fan_sel;
  } pad_provoke_type;

endpackage

// *** hdl/pad_fifo.sv ***
// Parameterised vertex FIFO with valid/ready on both sides
`timescale 1ns/1ns
module pad_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16
) (
  // Clock and reset
  input  wire logic             clk,
  input  wire logic             srst,
  // Fill side
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  // Drain side
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic [WIDTH-1:0]      out_data
);
  localparam int AW = $clog2(DEPTH);

  typedef struct packed {
    logic [AW-1:0] wr_ptr;
    logic [AW-1:0] rd_ptr;
    logic [AW:0]   count;
  } pad_fifo_state_type;

  pad_fifo_state_type    st_q;
  pad_fifo_state_type    st_d;
  logic [WIDTH-1:0]      mem [DEPTH];
  logic                  push;
  logic                  pop;

  assign in_ready  = (st_q.count != (AW+1)'(DEPTH));
  assign out_valid = (st_q.count != '0);
  assign out_data  = mem[st_q.rd_ptr];
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;

  always_comb begin
    st_d = st_q;
    if (push) begin
      st_d.wr_ptr = st_q.wr_ptr + 1'b1;
    end
    if (pop) begin
      st_d.rd_ptr = st_q.rd_ptr + 1'b1;
    end
    st_d.count = st_q.count + (AW+1)'(push) - (AW+1)'(pop);
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  // Storage has no reset; only the pointers and count need a defined value
  always_ff @(posedge clk) begin
    if (push) begin
      mem[st_q.wr_ptr] <= in_data;
    end
  end
endmodule

// *** test/pad_decomposer_assertions.sv ***
// Port checker for the primitive assembly decomposer
`timescale 1ns/1ns
module pad_decomposer_assertions
  import pad_pkg::*;
(
  // Clock and reset
  input wire logic            clk,
  input wire logic            srst,
  // Configuration and vertex side
  input wire pad_provoke_type provoke_cfg,
  input wire logic            vtx_valid,
  input wire logic            vtx_ready,
  input wire pad_vertex_type  vtx_in,
  // Object side and status
  input wire logic            obj_valid,
  input wire logic            obj_ready,
  input wire pad_object_type  obj_out,
  input wire logic            busy
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);
  property p_hold; obj_valid && !obj_ready |=> obj_valid && $stable(obj_out); endproperty
  a_hold: assert property (p_hold) else $error("object dropped or changed under stall");
  property p_store; vtx_valid && vtx_ready |=> busy; endproperty
  a_store: assert property (p_store) else $error("taken vertex not held");
  property p_busy; obj_valid |-> busy; endproperty
  a_busy: assert property (p_busy) else $error("object offered while idle");
  property p_full; !vtx_ready |-> busy; endproperty
  a_full: assert property (p_full) else $error("refusing vertices while empty");
  property p_pt; obj_valid && obj_out.object_kind == obj_point
    |-> obj_out.object_vertex_count == VCNT_POINT && obj_out.flat_shade_vertex_sel == 2'h0; endproperty
  a_pt: assert property (p_pt) else $error("bad point object");
  property p_ln; obj_valid && obj_out.object_kind == obj_line
    |-> obj_out.object_vertex_count == VCNT_LINE && obj_out.flat_shade_vertex_sel == provoke_cfg.line_sel;
  endproperty
  a_ln: assert property (p_ln) else $error("bad line object");
  property p_tri; obj_valid && obj_out.object_kind == obj_triangle |-> obj_out.object_vertex_count == VCNT_TRI;
  endproperty
  a_tri: assert property (p_tri) else $error("bad triangle count");
  property p_rect; obj_valid && obj_out.object_kind == obj_rectangle
    |-> obj_out.object_vertex_count == VCNT_RECT && obj_out.flat_shade_vertex_sel == 2'h0; endproperty
  a_rect: assert property (p_rect) else $error("bad rectangle object");
endmodule
bind pad_decomposer pad_decomposer_assertions u_pad_decomposer_assertions (.clk(clk), .srst(srst),
  .provoke_cfg(provoke_cfg), .vtx_valid(vtx_valid), .vtx_ready(vtx_ready), .vtx_in(vtx_in),
  .obj_valid(obj_valid), .obj_ready(obj_ready), .obj_out(obj_out), .busy(busy));

// *** test/pad_sink_model.sv ***
// Object setup stand-in that accepts promptly, slowly or not at all
`timescale 1ns/1ns
module pad_sink_model (
  // Clock
  input  wire logic clk,
  // Pace control
  input  wire logic hold,
  input  wire logic slow,
  // Accept strobe
  output logic      obj_ready
);
  initial obj_ready = 1'b0;
  always @(negedge clk) begin
    obj_ready <= !hold && (!slow || !obj_ready);
  end
endmodule

// *** test/tb_top.sv ***
// Self-checking bench for the decomposer
`timescale 1ns/1ns
module tb_top;
  import pad_pkg::*;
  logic            clk = 1'b0;
  logic            srst = 1'b1;
  logic            vtx_valid = 1'b0;
  logic            vtx_ready;
  pad_vertex_type  vtx_in = '0;
  logic            obj_valid;
  logic            obj_ready;
  pad_object_type  obj_out;
  logic            busy;
  logic            hold = 1'b0;
  logic            slow = 1'b0;
  pad_provoke_type cfg = {2'h1, 2'h2, 2'h1};
  int              error_cnt = 0;
  int              checked = 0;
  int              cyc = 0;
  logic [7:0]      tp = 8'h00;
  pad_object_type  got[$];

  always #20 clk = ~clk;

  pad_decomposer u_pad_decomposer (.clk(clk), .srst(srst), .provoke_cfg(cfg), .vtx_valid(vtx_valid),
    .vtx_ready(vtx_ready), .vtx_in(vtx_in), .obj_valid(obj_valid), .obj_ready(obj_ready),
    .obj_out(obj_out), .busy(busy));
  pad_sink_model u_pad_sink_model (.clk(clk), .hold(hold), .slow(slow), .obj_ready(obj_ready));

  function automatic logic [31:0] vd(int i); return {16'h0000, tp, 8'(i)}; endfunction
  function automatic logic [3:0] vp(int i); return 4'(i + 1); endfunction
  function automatic logic [10:0] sl(int i); return 11'h400 | 11'(i); endfunction
  function automatic pad_object_type mk(pad_object_kind_type k, logic [1:0] n, int a, int b, int c,
                                        logic fl, logic re, logic [1:0] s, logic pa, logic ca);
    return '{k, n, vd(a), vd(b), vd(c), fl, re, s, pa, ca, vp(a), sl(a)};
  endfunction

  task automatic tally_and_finish;
    $display("errors %0d checks %0d", error_cnt, checked);
    if (error_cnt == 0 && checked > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (!srst && obj_valid === 1'b1 && obj_ready) begin
      got.push_back(obj_out);
    end
    if (cyc == 20000) begin
      error_cnt++;
      tally_and_finish;
    end
  end

  task automatic chk_val(input logic [31:0] g, input logic [31:0] e);
    checked++;
    if (g !== e) begin
      error_cnt++;
      $display("[FAIL] %0t value %h expected %h", $time, g, e);
    end
  endtask

  // Fields that the object kind leaves meaningless are not compared
  task automatic chk_obj(input pad_object_type e);
    pad_object_type g;
    g = got.size() > 0 ? got.pop_front() : ~e;
    if (!e.object_kind[1]) g.vertex2 = e.vertex2;
    if (e.object_kind != obj_triangle) g.flip_winding = e.flip_winding;
    if (e.object_kind != obj_triangle) g.polygon_pattern_on = e.polygon_pattern_on;
    if (e.object_kind != obj_line) g.line_pattern_carry = e.line_pattern_carry;
    if (e.object_kind[1]) g.rear_facing = e.rear_facing;
    if (e.object_kind == obj_point) g.vertex1 = e.vertex1;
    checked++;
    if (g !== e) begin
      error_cnt++;
      $display("[FAIL] %0t object %h expected %h", $time, g, e);
    end
  endtask

  task automatic send(input pad_topology_kind_type k, input int n);
    tp = tp + 8'h01;
    for (int i = 0; i < n; i++) begin
      @(negedge clk);
      vtx_valid = 1'b1;
      vtx_in = '{k, i == 0, i == n - 1, vd(i), vp(i), sl(i)};
      while (vtx_ready !== 1'b1) @(negedge clk);
      @(posedge clk);
    end
    @(negedge clk);
    vtx_valid = 1'b0;
  endtask

  task automatic drain(input int n);
    for (int i = 0; i < 300 && got.size() < n; i++) @(negedge clk);
    repeat (6) @(negedge clk);
    chk_val(got.size(), n);
    chk_val(busy, 0);
  endtask

  task automatic t_points;
    for (int r = 0; r < 2; r++) begin
      send(r ? topo_point_list_rear : topo_point_list, 3);
      drain(3);
      for (int i = 0; i < 3; i++) chk_obj(mk(obj_point, VCNT_POINT, i, 0, 0, 0, r, 2'h0, 0, 0));
    end
    $display("test points done");
  endtask

  task automatic t_lines;
    send(topo_line_list, 4);
    drain(2);
    chk_obj(mk(obj_line, VCNT_LINE, 0, 1, 0, 0, 0, cfg.line_sel, 0, 0));
    chk_obj(mk(obj_line, VCNT_LINE, 2, 3, 0, 0, 0, cfg.line_sel, 0, 0));
    $display("test lines done");
  endtask

  task automatic t_strips;
    pad_topology_kind_type ks[4] = '{topo_line_strip, topo_line_strip_rear, topo_line_strip_carry,
                                     topo_line_strip_carry_rear};
    logic [7:0] t0;
    t0 = tp;
    slow = 1'b1;
    foreach (ks[j]) send(ks[j], 3);
    drain(8);
    foreach (ks[j]) begin
      tp = t0 + 8'(j + 1);
      chk_obj(mk(obj_line, VCNT_LINE, 0, 1, 0, 0, j[0], cfg.line_sel, 0, j[1]));
      chk_obj(mk(obj_line, VCNT_LINE, 1, 2, 0, 0, j[0], cfg.line_sel, 0, 1));
    end
    $display("test strips done");
  endtask

  task automatic t_tris;
    send(topo_tri_list, 6);
    send(topo_rect_list, 3);
    drain(3);
    tp = tp - 8'h01;
    chk_obj(mk(obj_triangle, VCNT_TRI, 0, 1, 2, 0, 0, cfg.tri_sel, 1, 0));
    chk_obj(mk(obj_triangle, VCNT_TRI, 3, 4, 5, 0, 0, cfg.tri_sel, 1, 0));
    tp = tp + 8'h01;
    chk_obj(mk(obj_rectangle, VCNT_RECT, 0, 1, 2, 0, 0, 2'h0, 0, 0));
    $display("test triangles done");
  endtask

  task automatic t_fan;
    send(topo_tri_fan_plain, 4);
    drain(2);
    chk_obj(mk(obj_triangle, VCNT_TRI, 0, 1, 2, 0, 0, cfg.fan_sel, 0, 0));
    chk_obj(mk(obj_triangle, VCNT_TRI, 0, 2, 3, 0, 0, cfg.fan_sel, 0, 0));
    $display("test fan done");
  endtask

  // Strips alternate winding; fans use the fan selector; polygons force selector zero
  task automatic t_more;
    logic [7:0] t0;
    t0 = tp;
    cfg.tri_sel = 2'h1;
    cfg.fan_sel = 2'h2;
    send(topo_tri_strip, 4);
    send(topo_tri_strip_rev, 4);
    send(topo_tri_fan, 3);
    send(topo_polygon, 3);
    drain(6);
    for (int j = 0; j < 2; j++) begin
      tp = t0 + 8'(j + 1);
      chk_obj(mk(obj_triangle, VCNT_TRI, 0, 1, 2, j[0], 0, cfg.tri_sel, 1, 0));
      chk_obj(mk(obj_triangle, VCNT_TRI, 1, 2, 3, !j[0], 0, cfg.tri_sel, 1, 0));
    end
    tp = t0 + 8'h03;
    chk_obj(mk(obj_triangle, VCNT_TRI, 0, 1, 2, 0, 0, cfg.fan_sel, 1, 0));
    tp = t0 + 8'h04;
    chk_obj(mk(obj_triangle, VCNT_TRI, 0, 1, 2, 0, 0, 2'h0, 1, 0));
    $display("test tri strips and fans done");
  endtask

  task automatic t_stall;
    slow = 1'b0;
    hold = 1'b1;
    fork
      send(topo_point_list, 24);
    join_none
    repeat (40) @(negedge clk);
    chk_val(vtx_ready, 0);
    chk_val(got.size(), 0);
    hold = 1'b0;
    drain(24);
    for (int i = 0; i < 24; i++) chk_obj(mk(obj_point, VCNT_POINT, i, 0, 0, 0, 0, 2'h0, 0, 0));
    $display("test stall done");
  endtask

  initial begin
    repeat (8) @(negedge clk);
    srst = 1'b0;
    t_points;
    t_lines;
    t_strips;
    t_tris;
    t_fan;
    t_more;
    t_stall;
    tally_and_finish;
  end
endmodule
